// [hw/ifr_pkg.sv]
// Package for the interrupt flag status bank: offsets, bit positions, resets.
// Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
package ifr_pkg;
    // Register byte offsets
    localparam logic [4:0] IFR_OFF_FLAGS_TWO = 5'h00;
    localparam logic [4:0] IFR_OFF_FLAGS_THREE = 5'h04;
    localparam logic [4:0] IFR_OFF_FLAGS_FOUR = 5'h08;
    localparam logic [4:0] IFR_OFF_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] IFR_OFF_IRQ_MASK = 5'h10;
    // Flag bit positions
    localparam int IFR_BIT_CAPTURE_CH3 = 5;
    localparam int IFR_BIT_PWM_FAULT_A = 15;
    localparam int IFR_BIT_CALENDAR = 14;
    localparam int IFR_BIT_PWM_GEN = 9;
    localparam int IFR_BIT_CHARGE = 13;
    localparam int IFR_BIT_SERIAL_ERR = 1;
    localparam int IFR_BIT_PWM_FAULT_B = 0;
    // Implemented-bit masks per flag word
    localparam logic [15:0] IFR_MASK_TWO = 16'h0020;
    localparam logic [15:0] IFR_MASK_THREE = 16'hc200;
    localparam logic [15:0] IFR_MASK_FOUR = 16'h2003;
    // Reset values
    localparam logic [15:0] IFR_RST_FLAGS = 16'h0000;
    localparam logic [2:0] IFR_RST_IRQ = 3'h0;
    // Number of event sources and flag words
    localparam int IFR_NUM_SRC = 7;
    localparam int IFR_NUM_WORDS = 3;
endpackage

// [hw/ifr_pulse_sync.sv]
// Two-flop synchroniser with rising-edge detect for one event line.
// Assumes the event line may come from another clock or a pin.
`timescale 1ns/1ps
module ifr_pulse_sync (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic level_i,
    output logic pulse_o
);
    logic meta_r; // First stage, read only by sync_r
    logic sync_r; // Second stage
    logic prev_r; // Delayed copy for edge detect

    // Synchroniser and edge history
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= level_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // One-cycle pulse on a rising request
    assign pulse_o = sync_r & ~prev_r;
endmodule // ifr_pulse_sync

// [hw/ifr_flag_word.sv]
// One 16-bit flag word: hardware sets, software writes, unimplemented bits zero.
// Assumes set pulses are synchronous to clk_sys_i.
`timescale 1ns/1ps
module ifr_flag_word #(
    parameter logic [15:0] IMPL = 16'h0000
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [15:0] set_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] flags_o
);
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;

    // Software write first, then hardware sets win over cleared bits
    always_comb begin
        flags_nxt = flags_r;
        if (wr_i) begin
            flags_nxt = wdata_i;
        end
        flags_nxt = (flags_nxt | set_i) & IMPL;
    end

    // Flag storage, cleared at reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_r <= 16'h0000;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;
endmodule // ifr_flag_word

// [hw/ifr_flag_bank.sv]
// Top of the interrupt request flag bank with its Avalon-MM register slave.
// Assumes peripheral request lines are levels, possibly from other domains;
// a rising edge on a line is one request.
`timescale 1ns/1ps

// How it works
// - Capture channel 3 flag at word two bit 5
// - PWM fault A flag at word three bit 15
// - Calendar clock flag at word three bit 14
// - PWM generator flag at word three bit 9
// - Flag one means request occurred, zero none
// - Unimplemented flag bits always read zero
module ifr_flag_bank
    import ifr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // Peripheral request lines
    input wire logic capture_ch3_req_i,
    input wire logic pwm_fault_a_req_i,
    input wire logic calendar_clock_req_i,
    input wire logic pwm_generator_req_i,
    input wire logic charge_measure_req_i,
    input wire logic serial_error_req_i,
    input wire logic pwm_fault_b_req_i,
    // Flag words for the arbitration logic
    output logic [15:0] event_flags_word_two_o,
    output logic [15:0] event_flags_word_three_o,
    output logic [15:0] event_flags_word_four_o,
    // Summary interrupt
    output logic irq_o
);
    typedef enum logic [1:0] {IFR_IDLE, IFR_ANSWER, IFR_DONE} ifr_bus_state_t;

    // Register map, byte offsets on the slave port:
    //   0x00 flag word two, one live bit
    //   0x04 flag word three, three live bits
    //   0x08 flag word four, three live bits
    //   0x0c summary status, one bit per word
    //   0x10 summary mask, same layout
    // Any other offset answers with a slave error.
    // Flag words sit in the low half of the data bus;
    // the upper half always reads back as zero.
    // Flags are plain read-write storage: software
    // may set a flag to test its handler, or clear
    // it once serviced. Unused bits drop on write.
    // Summary status bits are sticky and clear only
    // when software writes a one to them.
    // Nothing in this bank ever clears a flag on
    // its own; the interrupt service code owns it.

    // Request path
    logic [IFR_NUM_SRC-1:0] req_lines; // Raw request lines
    logic [IFR_NUM_SRC-1:0] req_pulse; // Synchronised request pulses
    logic [15:0] set_two; // Set vector word two
    logic [15:0] set_three; // Set vector word three
    logic [15:0] set_four; // Set vector word four
    logic [15:0] flags_two; // Flag word two
    logic [15:0] flags_three; // Flag word three
    logic [15:0] flags_four; // Flag word four

    // Summary interrupt
    logic [2:0] irq_event; // Per-word new-request events
    logic [2:0] irq_status_r; // Sticky word-event status
    logic [2:0] irq_mask_r; // Enable per word
    logic irq_r; // Registered interrupt

    // Bus slave
    ifr_bus_state_t bus_state_r; // Bus handshake state
    logic [31:0] rdata_r; // Registered read data
    logic [1:0] resp_r; // Registered response
    logic wait_r; // Registered waitrequest
    logic acc_wr; // Write accepted this cycle
    logic acc_rd; // Read accepted this cycle

    // Write path
    logic [15:0] wdata16; // Write data masked by lanes
    logic [15:0] lane_mask; // Byte-lane bit mask
    logic wr_two; // Write strobe word two
    logic wr_three; // Write strobe word three
    logic wr_four; // Write strobe word four
    logic addr_hit; // Address is mapped
    logic [15:0] cur_word; // Current word under write

    // Gather the request lines into one vector so
    // the synchroniser loop below can index them.
    assign req_lines = {pwm_fault_b_req_i, serial_error_req_i, charge_measure_req_i,
                        pwm_generator_req_i, calendar_clock_req_i, pwm_fault_a_req_i,
                        capture_ch3_req_i};

    // Request timing, counted from the edge that
    // first samples a line high:
    //   edge 1 first stage captures the level
    //   edge 2 second stage holds a settled copy
    //   edge 3 flag word stores the one-cycle pulse
    //   edge 4 arbiter copy of the word follows
    // The summary status bit sets at edge 3 too,
    // and the interrupt output one edge later.
    // A line held high counts once; it must drop
    // and rise again to raise another request.
    // Pulses shorter than a clock may be missed.
    // Each request line passes two flops, then an edge detect
    genvar g;
    generate
        for (g = 0; g < IFR_NUM_SRC; g++) begin : g_sync
            ifr_pulse_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .rst_b_i(rst_b_i),
                .level_i(req_lines[g]),
                .pulse_o(req_pulse[g])
            );
        end
    endgenerate

    // Route each pulse to its fixed flag bit.
    // Source order on req_pulse follows req_lines:
    // 0 capture, 1 fault A, 2 calendar, 3 generator,
    // 4 charge, 5 serial error, 6 fault B.
    // All other set bits stay zero, so no source
    // can reach an unused position.
    // Bit positions come from the package.
    always_comb begin
        set_two = 16'h0000;
        set_three = 16'h0000;
        set_four = 16'h0000;
        set_two[IFR_BIT_CAPTURE_CH3] = req_pulse[0];
        set_three[IFR_BIT_PWM_FAULT_A] = req_pulse[1];
        set_three[IFR_BIT_CALENDAR] = req_pulse[2];
        set_three[IFR_BIT_PWM_GEN] = req_pulse[3];
        set_four[IFR_BIT_CHARGE] = req_pulse[4];
        set_four[IFR_BIT_SERIAL_ERR] = req_pulse[5];
        set_four[IFR_BIT_PWM_FAULT_B] = req_pulse[6];
    end

    // Bus decode. A write lands only in the answer
    // state, on the edge where waitrequest is seen
    // low; in idle the request is merely noticed.
    // Address decode is exact, so aliases of the
    // mapped offsets fall into the error space.
    // Accepted bus accesses happen in the answer state only
    assign acc_wr = (bus_state_r == IFR_ANSWER) && avs_write_i;
    assign acc_rd = (bus_state_r == IFR_ANSWER) && avs_read_i;
    assign addr_hit = (avs_address_i == IFR_OFF_FLAGS_TWO) ||
                      (avs_address_i == IFR_OFF_FLAGS_THREE) ||
                      (avs_address_i == IFR_OFF_FLAGS_FOUR) ||
                      (avs_address_i == IFR_OFF_IRQ_STATUS) ||
                      (avs_address_i == IFR_OFF_IRQ_MASK);
    assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wr_two = acc_wr && (avs_address_i == IFR_OFF_FLAGS_TWO);
    assign wr_three = acc_wr && (avs_address_i == IFR_OFF_FLAGS_THREE);
    assign wr_four = acc_wr && (avs_address_i == IFR_OFF_FLAGS_FOUR);

    // Byte lanes: lane 0 covers flag bits 7:0 and
    // lane 1 bits 15:8. A lane left disabled keeps
    // its old contents, so software may touch one
    // half of a word without a read first.
    // Offsets outside the flag words merge with
    // word four, which is harmless: no strobe fires.
    // Merge written lanes with current contents
    always_comb begin
        case (avs_address_i)
            IFR_OFF_FLAGS_TWO: cur_word = flags_two;
            IFR_OFF_FLAGS_THREE: cur_word = flags_three;
            default: cur_word = flags_four;
        endcase
        wdata16 = (avs_writedata_i[15:0] & lane_mask) | (cur_word & ~lane_mask);
    end

    // Three flag words, one instance each. The
    // implemented-bit mask forces unused bits to
    // zero both on write and on hardware set.
    // Flag word two: capture channel 3 only
    ifr_flag_word #(.IMPL(IFR_MASK_TWO)) u_word_two (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(set_two),
        .wr_i(wr_two),
        .wdata_i(wdata16),
        .flags_o(flags_two)
    );

    // Flag word three: fault A, calendar, PWM generator
    ifr_flag_word #(.IMPL(IFR_MASK_THREE)) u_word_three (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(set_three),
        .wr_i(wr_three),
        .wdata_i(wdata16),
        .flags_o(flags_three)
    );

    // Flag word four: charge, serial error, fault B
    ifr_flag_word #(.IMPL(IFR_MASK_FOUR)) u_word_four (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(set_four),
        .wr_i(wr_four),
        .wdata_i(wdata16),
        .flags_o(flags_four)
    );

    // Per-word event: any set pulse in the word.
    // A write by software raises no event here.
    // Any new request in a word is a status event
    assign irq_event = {|set_four, |set_three, |set_two};

    // Summary status: a bit rises whenever any flag
    // of its word receives a new hardware request.
    // Software writes of the flag words themselves
    // do not touch it. When a clear and a new event
    // meet in one cycle the event wins, so no
    // request is lost between read and clear.
    // Write data bits 2:0 map onto words two to four.
    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_status_r <= IFR_RST_IRQ;
        end else begin
            if (acc_wr && avs_address_i == IFR_OFF_IRQ_STATUS && avs_byteenable_i[0]) begin
                irq_status_r <= (irq_status_r & ~avs_writedata_i[2:0]) | irq_event;
            end else begin
                irq_status_r <= irq_status_r | irq_event;
            end
        end
    end

    // A mask bit of one lets its status bit reach
    // the interrupt output; reset masks everything.
    // Interrupt mask register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_mask_r <= IFR_RST_IRQ;
        end else if (acc_wr && avs_address_i == IFR_OFF_IRQ_MASK && avs_byteenable_i[0]) begin
            irq_mask_r <= avs_writedata_i[2:0];
        end
    end

    // The output stays high for as long as any
    // enabled status bit is set; it is a level,
    // not a pulse, and drops one edge after clear.
    // Registered level interrupt
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_status_r & irq_mask_r);
        end
    end

    // Handshake walk for any access:
    //   edge 1 idle sees read or write, loads data
    //   edge 2 answer state, waitrequest is low;
    //          a write takes effect here
    //   edge 3 done state, waitrequest high again
    //   edge 4 back in idle, a new request may be seen
    // The done state keeps a request that is still
    // held after acceptance from being taken twice.
    // Every access costs one wait cycle; there is
    // no path that answers in the first cycle.
    // Masters must hold the request until
    // waitrequest is seen low; one that drops it
    // early gets no write and stale read data.
    // Bus handshake: one wait cycle, then answer, then release
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_state_r <= IFR_IDLE;
            wait_r <= 1'b1;
        end else begin
            case (bus_state_r)
                IFR_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_state_r <= IFR_ANSWER;
                        wait_r <= 1'b0;
                    end
                end
                IFR_ANSWER: begin
                    bus_state_r <= IFR_DONE;
                    wait_r <= 1'b1;
                end
                IFR_DONE: begin
                    bus_state_r <= IFR_IDLE;
                end
                default: begin
                    bus_state_r <= IFR_IDLE;
                    wait_r <= 1'b1;
                end
            endcase
        end
    end

    // Read data is sampled one edge before the
    // answer, so a flag set during the wait cycle
    // shows up on the next read, not this one.
    // Response 0 is okay, 3 a slave error for an
    // unmapped offset; both hold until the next
    // access starts.
    // Read data and response, loaded on entry to the answer state
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0000_0000;
            resp_r <= 2'h0;
        end else if (bus_state_r == IFR_IDLE && (avs_read_i || avs_write_i)) begin
            resp_r <= addr_hit ? 2'h0 : 2'h3;
            case (avs_address_i)
                IFR_OFF_FLAGS_TWO: rdata_r <= {16'h0000, flags_two};
                IFR_OFF_FLAGS_THREE: rdata_r <= {16'h0000, flags_three};
                IFR_OFF_FLAGS_FOUR: rdata_r <= {16'h0000, flags_four};
                IFR_OFF_IRQ_STATUS: rdata_r <= {29'h0000_0000, irq_status_r};
                IFR_OFF_IRQ_MASK: rdata_r <= {29'h0000_0000, irq_mask_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (acc_rd) begin
            rdata_r <= rdata_r;
        end
    end

    // Arbiter copies come straight from flops so
    // the priority logic sees settled values; the
    // price is one cycle of extra latency.
    // They are not gated by the mask register.
    // Flag words out to the arbiter, one cycle behind storage
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            event_flags_word_two_o <= IFR_RST_FLAGS;
            event_flags_word_three_o <= IFR_RST_FLAGS;
            event_flags_word_four_o <= IFR_RST_FLAGS;
        end else begin
            event_flags_word_two_o <= flags_two;
            event_flags_word_three_o <= flags_three;
            event_flags_word_four_o <= flags_four;
        end
    end

    // Output ports, each fed by a register above
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign avs_response_o = resp_r;
    assign irq_o = irq_r;
endmodule // ifr_flag_bank

// [bench/ifr_flag_bank_properties.sv]
// Checker for the flag bank: source-to-flag mapping and zero bits.
// Assumes it is bound to ifr_flag_bank and sees its ports only.
`timescale 1ns/1ps
module ifr_flag_bank_properties (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic capture_ch3_req_i,
    input wire logic pwm_fault_a_req_i,
    input wire logic calendar_clock_req_i,
    input wire logic pwm_generator_req_i,
    input wire logic charge_measure_req_i,
    input wire logic serial_error_req_i,
    input wire logic pwm_fault_b_req_i,
    input wire logic [15:0] event_flags_word_two_o,
    input wire logic [15:0] event_flags_word_three_o,
    input wire logic [15:0] event_flags_word_four_o
);
    // One clock domain, async reset
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    a_unimpl_reads_zero: assert property ((event_flags_word_two_o & ~16'h0020) == 16'h0000 && (event_flags_word_three_o & ~16'hc200) == 16'h0000 && (event_flags_word_four_o & ~16'h2003) == 16'h0000)
        else $error("unimplemented flag bit seen high");
    a_flags_clear_start: assert property (!$past(rst_b_i) |-> (event_flags_word_two_o | event_flags_word_three_o | event_flags_word_four_o) == 16'h0000)
        else $error("flag high right after reset");
    a_capture_sets: assert property ($rose(capture_ch3_req_i) |-> ##[3:8] event_flags_word_two_o[5])
        else $error("capture flag not set");
    a_fault_a_sets: assert property ($rose(pwm_fault_a_req_i) |-> ##[3:8] event_flags_word_three_o[15])
        else $error("fault a flag not set");
    a_calendar_sets: assert property ($rose(calendar_clock_req_i) |-> ##[3:8] event_flags_word_three_o[14])
        else $error("calendar flag not set");
    a_pwm_gen_sets: assert property ($rose(pwm_generator_req_i) |-> ##[3:8] event_flags_word_three_o[9])
        else $error("pwm generator flag not set");
    a_charge_sets: assert property ($rose(charge_measure_req_i) |-> ##[3:8] event_flags_word_four_o[13])
        else $error("charge flag not set");
    a_serial_sets: assert property ($rose(serial_error_req_i) |-> ##[3:8] event_flags_word_four_o[1])
        else $error("serial error flag not set");
    a_fault_b_sets: assert property ($rose(pwm_fault_b_req_i) |-> ##[3:8] event_flags_word_four_o[0])
        else $error("fault b flag not set");
    // Main scenarios
    c_capture: cover property ($rose(event_flags_word_two_o[5]));
    c_fault_a: cover property ($rose(event_flags_word_three_o[15]));
    c_charge: cover property ($rose(event_flags_word_four_o[13]));
endmodule // ifr_flag_bank_properties
bind ifr_flag_bank ifr_flag_bank_properties i_ifr_flag_bank_properties (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .capture_ch3_req_i(capture_ch3_req_i),
    .pwm_fault_a_req_i(pwm_fault_a_req_i), .calendar_clock_req_i(calendar_clock_req_i),
    .pwm_generator_req_i(pwm_generator_req_i), .charge_measure_req_i(charge_measure_req_i),
    .serial_error_req_i(serial_error_req_i), .pwm_fault_b_req_i(pwm_fault_b_req_i),
    .event_flags_word_two_o(event_flags_word_two_o),
    .event_flags_word_three_o(event_flags_word_three_o),
    .event_flags_word_four_o(event_flags_word_four_o));

// [bench/ifr_src_model.sv]
// Peripheral request sources: each line follows its fire bit, registered.
// Assumes the bench holds a fire bit for several cycles per request.
`timescale 1ns/1ps
module ifr_src_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [6:0] fire_i,
    output logic [6:0] req_o
);
    // Lines idle low, rise once per request
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_o <= 7'h00;
        end else begin
            req_o <= fire_i;
        end
    end
endmodule // ifr_src_model

// [bench/ifr_flag_bank_tb_top.sv]
// Bench for the flag bank: register access, source mapping, summary irq.
// Assumes the Avalon slave answers after one wait cycle.
`timescale 1ns/1ps
module ifr_flag_bank_tb_top;
    import ifr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic wait_o;
    logic [1:0] resp;
    logic [6:0] fire = 7'h00;
    logic [6:0] req;
    logic irq;
    logic [31:0] q;
    logic [3:0] be = 4'hf; // Byte enables
    logic [15:0] fw2, fw3, fw4, fwq; // Flag word outputs
    int mismatches = 0;
    int n_checks = 0;
    // Source table: word offset and bit
    logic [4:0] src_off [7] = '{5'h00, 5'h04, 5'h04, 5'h04, 5'h08, 5'h08, 5'h08};
    int src_bit [7] = '{5, 15, 14, 9, 13, 1, 0};
    ifr_flag_bank i_ifr_flag_bank (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .avs_response_o(resp), .capture_ch3_req_i(req[0]), .pwm_fault_a_req_i(req[1]),
        .calendar_clock_req_i(req[2]), .pwm_generator_req_i(req[3]),
        .charge_measure_req_i(req[4]), .serial_error_req_i(req[5]),
        .pwm_fault_b_req_i(req[6]), .event_flags_word_two_o(fw2),
        .event_flags_word_three_o(fw3), .event_flags_word_four_o(fw4), .irq_o(irq));
    ifr_src_model i_ifr_src_model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .fire_i(fire), .req_o(req));
    // Clock, 200 MHz
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_sys_i);
        while (wait_o !== 1'b0) @(posedge clk_sys_i);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic fire_src(input int i);
        fire[i] <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        fire[i] <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
    endtask
    // Reset values and an unmapped place
    task automatic t_reset();
        for (int a = 0; a < 5; a++) begin
            acc(1'b0, 5'(a * 4), 32'h0);
            chk("reset value", q, 32'h0);
            chk("mapped response", {30'h0, resp}, 32'h0);
        end
        acc(1'b0, 5'h14, 32'h0);
        chk("unmapped read", q, 32'h0);
        chk("unmapped response", {30'h0, resp}, 32'h3);
    endtask
    // Writable bits only: all ones reads back the implemented mask
    task automatic t_write_mask();
        acc(1'b1, IFR_OFF_FLAGS_TWO, 32'hffffffff);
        acc(1'b0, IFR_OFF_FLAGS_TWO, 32'h0);
        chk("word two mask", q, {16'h0, IFR_MASK_TWO});
        acc(1'b1, IFR_OFF_FLAGS_THREE, 32'hffffffff);
        acc(1'b0, IFR_OFF_FLAGS_THREE, 32'h0);
        chk("word three mask", q, 32'h0000c200);
        acc(1'b1, IFR_OFF_FLAGS_FOUR, 32'hffffffff);
        acc(1'b0, IFR_OFF_FLAGS_FOUR, 32'h0);
        chk("word four mask", q, 32'h00002003);
        be <= 4'h1;
        acc(1'b1, IFR_OFF_FLAGS_FOUR, 32'h0);
        be <= 4'hf;
        acc(1'b0, IFR_OFF_FLAGS_FOUR, 32'h0);
        chk("word four lane one kept", q, 32'h00002000);
        for (int a = 0; a < 3; a++) acc(1'b1, 5'(a * 4), 32'h0);
    endtask
    // Each source sets only its own bit; software clears it
    task automatic t_sources();
        for (int i = 0; i < 7; i++) begin
            fire_src(i);
            acc(1'b0, src_off[i], 32'h0);
            chk("source flag", q, 32'h1 << src_bit[i]);
            fwq = (src_off[i] == IFR_OFF_FLAGS_TWO) ? fw2 :
                  (src_off[i] == IFR_OFF_FLAGS_THREE) ? fw3 : fw4;
            chk("flag word out", {16'h0, fwq}, 32'h1 << src_bit[i]);
            acc(1'b1, src_off[i], 32'h0);
            acc(1'b0, src_off[i], 32'h0);
            chk("cleared flag", q, 32'h0);
        end
    endtask
    // Summary interrupt: raise, mask, clear
    task automatic t_irq();
        acc(1'b0, IFR_OFF_IRQ_STATUS, 32'h0);
        chk("status after sources", q, 32'h7);
        acc(1'b1, IFR_OFF_IRQ_STATUS, 32'h7);
        fire_src(0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        acc(1'b0, IFR_OFF_IRQ_STATUS, 32'h0);
        chk("irq status", q, 32'h1);
        acc(1'b1, IFR_OFF_IRQ_MASK, 32'h7);
        repeat (3) @(posedge clk_sys_i);
        chk("irq raised", {31'h0, irq}, 32'h1);
        acc(1'b1, IFR_OFF_IRQ_STATUS, 32'h1);
        repeat (3) @(posedge clk_sys_i);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        acc(1'b1, IFR_OFF_IRQ_MASK, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_write_mask();
        t_sources();
        t_irq();
        tally_and_finish();
    end
endmodule // ifr_flag_bank_tb_top
